// [rtl/psg_cfg.svh]
/*
 * Constants of the PID supervision and gain switch block: register offsets,
 * limits, reset values and the fixed codes that steer the logic.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
// Overview of operation
// [R1] Select 0: flag on while feedback below lower or above upper bound.
// [R2] Select 4: flag on while feedback outside setpoint minus lower, plus upper.
// [R3] Select 0-3 absolute, 4-7 deviation; offsets add hold, latch, both.
// [R4] Hold keeps flag off from power-on until feedback leaves the trip range.
// [R5] Latch keeps the flag on after feedback leaves the trip range.
// [R6] Only keypad reset or reset terminal command clears a latched flag; the code also clears it when a select without latch is written.
// [R7] Upper trip setting is a percentage of the feedback quantity.
// [R8] Lower trip setting is a percentage of the feedback quantity.
// [R9] Percentages scale against feedback full scale at unity feedback gain.
// [R10] Flag reaches the output terminal only when its assignment code is 42.
// [R11] Upper clamp in percent; 999 selects the frequency high limiter.
// [R12] Lower clamp in percent; 999 selects the frequency low limiter.
// [R13] PID cancel input (code 20) with preset reference ignores the clamps.
// [R14] Dancer reference position holds -100 to +100 percent.
// [R15] Dancer reference setting is used only when command source is 0.
// [R16] Keypad up and down keys store the new value into the reference.
// [R17] Feedback inside reference plus or minus width selects gain set two.
// [R18] Width accepts 1 to 100 percent; 0 disables gain switching.
// [R19] Outside party assigns negative logic for in-range detection uses.
// [R20] PID output saturates between lower and upper clamp before use.
`ifndef PSG_CFG_SVH
`define PSG_CFG_SVH

`define PSG_ADDR_W        6
`define PSG_OFF_CFG       6'h00
`define PSG_OFF_TERM      6'h04
`define PSG_OFF_TRIP      6'h08
`define PSG_OFF_CLAMP     6'h0C
`define PSG_OFF_LIMIT     6'h10
`define PSG_OFF_PRESET    6'h14
`define PSG_OFF_DANCER    6'h18
`define PSG_OFF_GAIN0     6'h1C
`define PSG_OFF_STATUS    6'h34

`define PSG_CODE_SUPV     8'h2A
`define PSG_CODE_CANCEL   8'h14
`define PSG_CLAMP_USE_LIM 10'h3E7
`define PSG_PCT_MAX       8'h64
`define PSG_SRC_KEYPAD    2'h0
`define PSG_CLAMP_MAX     10'h064
`define PSG_CLAMP_SCALE   16'h000A

`define PSG_RST_CLAMP_UP  10'h064
`define PSG_RST_CLAMP_LO  10'h000
`define PSG_RST_LIM_HI    16'h03E8
`define PSG_RST_LIM_LO    16'h0000
`define PSG_RST_TRIP_UP   7'h64
`define PSG_RST_TRIP_LO   7'h00

`endif

// [rtl/psg_pkg.sv]
/*
 * Types shared by the PID supervision and gain switch block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package psg_pkg;

	typedef struct packed {
		logic [15:0] prop_gain;
		logic [15:0] integ_time;
		logic [15:0] deriv_time;
	} psg_gain_set_t;

	typedef enum logic [0:0] {
		PSG_HOLD_WAIT  = 1'b0,
		PSG_HOLD_ARMED = 1'b1
	} psg_hold_t;

	typedef struct packed {
		logic [2:0] trip_type_select;
		logic [1:0] command_source_select;
		logic       neg_logic;
	} psg_cfg_t;

endpackage : psg_pkg

// [rtl/psg_supervision_gain.sv]
/*
 * PID supervision, output clamp and dancer gain switch, with an APB slave.
 * Assumes feedback, setpoint, PID output and dancer position come from logic
 * on pclk; keypad keys and terminal inputs are asynchronous pins.
 */
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "psg_cfg.svh"

module psg_supervision_gain #(
	parameter int FB_W = 12
) (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Process values on pclk
	input  wire logic [FB_W-1:0]       process_feedback,
	input  wire logic [FB_W-1:0]       process_setpoint,
	input  wire logic signed [15:0]    pid_raw,
	input  wire logic signed [7:0]     dancer_feedback,
	input  wire logic signed [7:0]     ext_dancer_ref,
	// Asynchronous pins
	input  wire logic                  keypad_reset_key,
	input  wire logic                  reset_terminal_cmd,
	input  wire logic                  keypad_up_key,
	input  wire logic                  keypad_down_key,
	input  wire logic [6:0]            input_terminals,
	// Results
	output logic                       supervision_flag_out,
	output logic                       output_terminal,
	output logic signed [15:0]         pid_ref_out,
	output logic signed [7:0]          dancer_ref_out,
	output logic                       gain_set2_out,
	output psg_pkg::psg_gain_set_t     active_gains
);

	localparam int FB_FS = (1 << FB_W) - 1;

	if (FB_W < 4 || FB_W > 14) begin : g_bad_width
		$error("FB_W must lie between 4 and 14");
	end

	// Register storage.
	psg_pkg::psg_cfg_t      cfg_r;
	logic [7:0]             out_assign_r;
	logic [7:0]             in_assign_r;
	logic [2:0]             cancel_idx_r;
	logic [6:0]             trip_up_r;
	logic [6:0]             trip_lo_r;
	logic [9:0]             clamp_up_r;
	logic [9:0]             clamp_lo_r;
	logic signed [15:0]     lim_hi_r;
	logic signed [15:0]     lim_lo_r;
	logic signed [15:0]     preset_r;
	logic signed [7:0]      dref_r;
	logic [7:0]             dwidth_r;
	logic [15:0]            gain_r [6];

	// Pin synchronisers: three stages, a change counts when stages two and three agree.
	logic [10:0]            pin_s1_r;
	logic [10:0]            pin_s2_r;
	logic [10:0]            pin_s3_r;
	logic [10:0]            pin_st_r;
	logic [10:0]            pin_st_d_r;
	logic [10:0]            pins;

	assign pins = {input_terminals, keypad_down_key, keypad_up_key,
		reset_terminal_cmd, keypad_reset_key};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r   <= 11'h000;
			pin_s2_r   <= 11'h000;
			pin_s3_r   <= 11'h000;
			pin_st_r   <= 11'h000;
			pin_st_d_r <= 11'h000;
		end else begin
			pin_s1_r   <= pins;
			pin_s2_r   <= pin_s1_r;
			pin_s3_r   <= pin_s2_r;
			pin_st_r   <= (pin_s2_r & pin_s3_r) | (pin_st_r & (pin_s2_r | pin_s3_r));
			pin_st_d_r <= pin_st_r;
		end
	end

	logic [10:0] pin_rise;
	logic        alarm_clr;
	logic        key_up;
	logic        key_down;
	logic        cancel_act;

	assign pin_rise = pin_st_r & ~pin_st_d_r;
	// [R6] Reset sources
	assign alarm_clr = pin_rise[0] | pin_rise[1];
	assign key_up    = pin_rise[2];
	assign key_down  = pin_rise[3];
	// [R13] Cancel input
	// Index 7 names no terminal, so it never cancels instead of reading past the pins.
	assign cancel_act = (in_assign_r == `PSG_CODE_CANCEL) && (cancel_idx_r != 3'h7) &&
		pin_st_r[4 + cancel_idx_r];

	// APB decode: data is prepared in the setup cycle, so every access takes two cycles.
	logic                   apb_setup;
	logic                   apb_wr;
	logic [`PSG_ADDR_W-1:0] a_off;
	logic                   a_hit;
	logic                   a_gain;
	logic [2:0]             a_gidx;

	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pready && pwrite && !pslverr;
	assign a_off     = paddr[`PSG_ADDR_W-1:0];
	assign a_gain    = (a_off >= `PSG_OFF_GAIN0) && (a_off < `PSG_OFF_STATUS);
	assign a_gidx    = 3'((a_off - `PSG_OFF_GAIN0) >> 2);
	assign a_hit     = (paddr[31:`PSG_ADDR_W] == '0) && (a_off[1:0] == 2'h0) &&
		(a_off <= `PSG_OFF_STATUS);

	// Supervision state.
	logic                   sup_raw_r;
	logic                   latched_r;
	psg_pkg::psg_hold_t     hold_r;
	logic                   clamp_act_r;

	logic [31:0] status_word;
	logic [31:0] rd_word;

	assign status_word = {26'h0, cancel_act, clamp_act_r, gain_set2_out, latched_r,
		hold_r == psg_pkg::PSG_HOLD_ARMED, sup_raw_r};

	always_comb begin
		rd_word = 32'h0000_0000;
		if (a_gain) begin
			rd_word = {16'h0000, gain_r[a_gidx]};
		end else begin
			unique case (a_off)
				`PSG_OFF_CFG:    rd_word = {19'h0, cfg_r.neg_logic, 2'h0,
					cfg_r.command_source_select, 5'h0, cfg_r.trip_type_select};
				`PSG_OFF_TERM:   rd_word = {13'h0, cancel_idx_r, in_assign_r, out_assign_r};
				`PSG_OFF_TRIP:   rd_word = {9'h0, trip_lo_r, 9'h0, trip_up_r};
				`PSG_OFF_CLAMP:  rd_word = {6'h0, clamp_lo_r, 6'h0, clamp_up_r};
				`PSG_OFF_LIMIT:  rd_word = {lim_lo_r, lim_hi_r};
				`PSG_OFF_PRESET: rd_word = {16'h0, preset_r};
				`PSG_OFF_DANCER: rd_word = {16'h0, dwidth_r, dref_r};
				`PSG_OFF_STATUS: rd_word = status_word;
				default:         rd_word = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= apb_setup;
			pslverr <= apb_setup && !a_hit;
			if (apb_setup) begin
				prdata <= a_hit ? rd_word : 32'h0000_0000;
			end
		end
	end

	// Configuration registers written from the bus.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r        <= '0;
			out_assign_r <= 8'h00;
			in_assign_r  <= 8'h00;
			cancel_idx_r <= 3'h0;
			trip_up_r    <= `PSG_RST_TRIP_UP;
			trip_lo_r    <= `PSG_RST_TRIP_LO;
			clamp_up_r   <= `PSG_RST_CLAMP_UP;
			clamp_lo_r   <= `PSG_RST_CLAMP_LO;
			lim_hi_r     <= `PSG_RST_LIM_HI;
			lim_lo_r     <= `PSG_RST_LIM_LO;
			preset_r     <= 16'sh0000;
			dwidth_r     <= 8'h00;
		end else if (apb_wr) begin
			unique case (a_off)
				`PSG_OFF_CFG: begin
					// [R3] Select encoding
					cfg_r.trip_type_select      <= pwdata[2:0];
					cfg_r.command_source_select <= pwdata[9:8];
					cfg_r.neg_logic             <= pwdata[12];
				end
				`PSG_OFF_TERM: begin
					out_assign_r <= pwdata[7:0];
					in_assign_r  <= pwdata[15:8];
					cancel_idx_r <= pwdata[18:16];
				end
				`PSG_OFF_TRIP: begin
					trip_up_r <= (pwdata[7:0] > `PSG_PCT_MAX) ? 7'(`PSG_PCT_MAX) : pwdata[6:0];
					trip_lo_r <= (pwdata[23:16] > `PSG_PCT_MAX) ? 7'(`PSG_PCT_MAX) : pwdata[22:16];
				end
				`PSG_OFF_CLAMP: begin
					// [R11] Upper clamp write
					clamp_up_r <= (pwdata[9:0] == `PSG_CLAMP_USE_LIM) ? pwdata[9:0] :
						(pwdata[9:0] > `PSG_CLAMP_MAX) ? `PSG_CLAMP_MAX : pwdata[9:0];
					// [R12] Lower clamp write
					clamp_lo_r <= (pwdata[25:16] == `PSG_CLAMP_USE_LIM) ? pwdata[25:16] :
						(pwdata[25:16] > `PSG_CLAMP_MAX) ? `PSG_CLAMP_MAX : pwdata[25:16];
				end
				`PSG_OFF_LIMIT: begin
					lim_hi_r <= pwdata[15:0];
					lim_lo_r <= pwdata[31:16];
				end
				`PSG_OFF_PRESET: preset_r <= pwdata[15:0];
				`PSG_OFF_DANCER: begin
					// [R18] Width range
					dwidth_r <= (pwdata[15:8] > `PSG_PCT_MAX) ? `PSG_PCT_MAX : pwdata[15:8];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 6; i++) begin
				gain_r[i] <= 16'h0000;
			end
		end else if (apb_wr && a_gain) begin
			gain_r[a_gidx] <= pwdata[15:0];
		end
	end

	// Dancer reference: bus writes and keypad steps share one register.
	logic signed [8:0] dref_wr;

	assign dref_wr = 9'(signed'(pwdata[7:0]));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dref_r <= 8'sh00;
		end else if (apb_wr && a_off == `PSG_OFF_DANCER) begin
			// [R14] Reference range
			dref_r <= (dref_wr > 9'sd100) ? 8'sd100 :
				(dref_wr < -9'sd100) ? -8'sd100 : pwdata[7:0];
		end else if (cfg_r.command_source_select == `PSG_SRC_KEYPAD) begin
			// [R16] Keypad stores
			if (key_up && !key_down && dref_r < 8'sd100) begin
				dref_r <= dref_r + 8'sd1;
			end else if (key_down && !key_up && dref_r > -8'sd100) begin
				dref_r <= dref_r - 8'sd1;
			end
		end
	end

	// Trip bounds in feedback counts.
	logic [FB_W-1:0]          up_b;
	logic [FB_W-1:0]          lo_b;
	logic signed [FB_W+1:0]   fb_s;
	logic signed [FB_W+1:0]   sv_s;
	logic                     trip_cond;
	logic                     hold_mode;
	logic                     latch_mode;
	logic                     qual;

	// [R7] Upper as percent
	// [R9] Full-scale scaling
	assign up_b = FB_W'((32'(trip_up_r) * 32'(FB_FS)) / 32'd100);
	// [R8] Lower as percent
	assign lo_b = FB_W'((32'(trip_lo_r) * 32'(FB_FS)) / 32'd100);
	assign fb_s = signed'({2'b00, process_feedback});
	assign sv_s = signed'({2'b00, process_setpoint});

	always_comb begin
		if (cfg_r.trip_type_select[2]) begin
			// [R2] Deviation bounds
			trip_cond = (fb_s < sv_s - signed'({2'b00, lo_b})) ||
				(fb_s > sv_s + signed'({2'b00, up_b}));
		end else begin
			// [R1] Absolute bounds
			trip_cond = (process_feedback < lo_b) || (process_feedback > up_b);
		end
	end

	// [R3] Hold and latch bits
	assign hold_mode  = cfg_r.trip_type_select[0];
	assign latch_mode = cfg_r.trip_type_select[1];
	assign qual       = trip_cond && (!hold_mode || hold_r == psg_pkg::PSG_HOLD_ARMED);

	// [R4] Hold arming
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_r <= psg_pkg::PSG_HOLD_WAIT;
		end else if (!hold_mode) begin
			// Hold waits afresh whenever it is selected; the select resets to no hold.
			hold_r <= psg_pkg::PSG_HOLD_WAIT;
		end else begin
			unique case (hold_r)
				psg_pkg::PSG_HOLD_WAIT:  hold_r <= trip_cond ? psg_pkg::PSG_HOLD_WAIT :
					psg_pkg::PSG_HOLD_ARMED;
				psg_pkg::PSG_HOLD_ARMED: hold_r <= psg_pkg::PSG_HOLD_ARMED;
			endcase
		end
	end

	// [R5] Latch holds on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched_r <= 1'b0;
		end else if (latch_mode && qual) begin
			latched_r <= 1'b1;
		end else if (alarm_clr || !latch_mode) begin
			// [R6] Reset clears latch
			latched_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sup_raw_r            <= 1'b0;
			supervision_flag_out <= 1'b0;
			output_terminal      <= 1'b0;
		end else begin
			sup_raw_r            <= qual || latched_r;
			// [R10] Terminal assignment
			supervision_flag_out <= sup_raw_r && (out_assign_r == `PSG_CODE_SUPV);
			// [R19] Polarity for range use
			output_terminal      <= (out_assign_r == `PSG_CODE_SUPV) &&
				(sup_raw_r ^ cfg_r.neg_logic);
		end
	end

	// PID output clamp, units of 0.1 percent.
	logic signed [15:0] up_lim;
	logic signed [15:0] lo_lim;
	logic signed [15:0] clamped;

	// [R11] Upper clamp source
	assign up_lim = (clamp_up_r == `PSG_CLAMP_USE_LIM) ? lim_hi_r :
		16'(16'(clamp_up_r) * `PSG_CLAMP_SCALE);
	// [R12] Lower clamp source
	assign lo_lim = (clamp_lo_r == `PSG_CLAMP_USE_LIM) ? lim_lo_r :
		16'(16'(clamp_lo_r) * `PSG_CLAMP_SCALE);
	// [R20] Saturate output
	assign clamped = (pid_raw > up_lim) ? up_lim : (pid_raw < lo_lim) ? lo_lim : pid_raw;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pid_ref_out <= 16'sh0000;
			clamp_act_r <= 1'b0;
		end else if (cancel_act) begin
			// [R13] Clamps bypassed
			pid_ref_out <= preset_r;
			clamp_act_r <= 1'b0;
		end else begin
			pid_ref_out <= clamped;
			clamp_act_r <= (clamped != pid_raw);
		end
	end

	// Dancer gain switching.
	logic signed [7:0] dref_use;
	logic signed [8:0] ddev;
	logic              in_window;

	// [R15] Keypad source only
	assign dref_use  = (cfg_r.command_source_select == `PSG_SRC_KEYPAD) ? dref_r : ext_dancer_ref;
	assign ddev      = 9'(dancer_feedback) - 9'(dref_use);
	// [R18] Zero width disables
	assign in_window = (dwidth_r != 8'h00) &&
		(ddev <= signed'({1'b0, dwidth_r})) && (ddev >= -signed'({1'b0, dwidth_r}));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_set2_out  <= 1'b0;
			dancer_ref_out <= 8'sh00;
			active_gains   <= '0;
		end else begin
			gain_set2_out  <= in_window;
			dancer_ref_out <= dref_use;
			// [R17] Second gain set
			active_gains   <= in_window ? {gain_r[3], gain_r[4], gain_r[5]} :
				{gain_r[0], gain_r[1], gain_r[2]};
		end
	end

	property p_abs_trip;
		@(posedge pclk) disable iff (!presetn)
		(cfg_r.trip_type_select == 3'h0 && process_feedback > up_b) |=> sup_raw_r;
	endproperty
	a_abs_trip: assert property (p_abs_trip) else $error("absolute trip missed"); // [R1]

	property p_dev_trip;
		@(posedge pclk) disable iff (!presetn)
		(cfg_r.trip_type_select == 3'h4 && fb_s < sv_s - signed'({2'b00, lo_b})) |=> sup_raw_r;
	endproperty
	a_dev_trip: assert property (p_dev_trip) else $error("deviation trip missed"); // [R2]

	property p_hold_off;
		@(posedge pclk) disable iff (!presetn)
		(cfg_r.trip_type_select == 3'h1 && hold_r == psg_pkg::PSG_HOLD_WAIT) |=> !sup_raw_r;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("flag on before hold armed"); // [R4]

	property p_latch_keep;
		@(posedge pclk) disable iff (!presetn)
		(latched_r && latch_mode) |=> sup_raw_r;
	endproperty
	a_latch_keep: assert property (p_latch_keep) else $error("latched flag dropped"); // [R5]

	property p_latch_clear;
		@(posedge pclk) disable iff (!presetn)
		(latched_r && latch_mode && !alarm_clr && !qual) |=> latched_r;
	endproperty
	a_latch_clear: assert property (p_latch_clear) else $error("latch cleared without reset"); // [R6]

	property p_terminal;
		@(posedge pclk) disable iff (!presetn)
		(out_assign_r != `PSG_CODE_SUPV) |=> (!supervision_flag_out && !output_terminal);
	endproperty
	a_terminal: assert property (p_terminal) else $error("flag on unassigned terminal"); // [R10]

	property p_clamp_band;
		@(posedge pclk) disable iff (!presetn)
		(!cancel_act && lo_lim <= up_lim) |=> (pid_ref_out <= $past(up_lim) &&
			pid_ref_out >= $past(lo_lim));
	endproperty
	a_clamp_band: assert property (p_clamp_band) else $error("PID output outside clamps"); // [R20]

	property p_cancel;
		@(posedge pclk) disable iff (!presetn)
		cancel_act |=> (pid_ref_out == $past(preset_r));
	endproperty
	a_cancel: assert property (p_cancel) else $error("cancel did not bypass clamps"); // [R13]

	property p_gain_off;
		@(posedge pclk) disable iff (!presetn)
		(dwidth_r == 8'h00) |=> !gain_set2_out;
	endproperty
	a_gain_off: assert property (p_gain_off) else $error("gain switched with zero width"); // [R18]

	property p_dref_range;
		@(posedge pclk) disable iff (!presetn)
		(dref_r >= -8'sd100) && (dref_r <= 8'sd100);
	endproperty
	a_dref_range: assert property (p_dref_range) else $error("dancer reference out of range"); // [R14]

endmodule : psg_supervision_gain

`default_nettype wire

// [dv/psg_sensor_model.sv]
/*
 * Far-side model: feedback sensor, setpoint source and operator pins.
 * Assumes requests from the bench on pclk; pins change only after an edge.
 */
`timescale 1ns/1ps
`default_nettype none

module psg_sensor_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Requests from the bench
	input  wire logic [11:0] fb_req,
	input  wire logic [11:0] sp_req,
	input  wire logic        rst_req,
	input  wire logic        up_req,
	input  wire logic        dn_req,
	// Pins toward the block
	output logic      [11:0] process_feedback,
	output logic      [11:0] process_setpoint,
	output logic             reset_terminal_cmd,
	output logic             keypad_up_key,
	output logic             keypad_down_key
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			process_feedback <= 12'h000;
			process_setpoint <= 12'h000;
		end else begin
			process_feedback <= fb_req;
			process_setpoint <= sp_req;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_terminal_cmd <= 1'b0;
			keypad_up_key      <= 1'b0;
			keypad_down_key    <= 1'b0;
		end else begin
			reset_terminal_cmd <= rst_req;
			keypad_up_key      <= up_req;
			keypad_down_key    <= dn_req;
		end
	end
endmodule : psg_sensor_model

`default_nettype wire

// [dv/psg_supervision_gain_bench.sv]
/*
 * Self-checking bench for the supervision and gain switch block.
 * Assumes a two-cycle APB access and the sensor model beside the block.
 */
`timescale 1ns/1ps
`default_nettype none
`include "psg_cfg.svh"

module psg_supervision_gain_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, r;
	logic pready, pslverr, e, flag, term, gs2, krst = 0, rreq = 0, up = 0, dn = 0;
	logic [11:0] fb_req = 0, sp_req = 0, fb, sp;
	logic signed [15:0] pid_raw = 0, pid_ref;
	logic signed [7:0] dfb = 0, ext_ref = 0, dref;
	logic [6:0] terms = 0;
	logic rst_pin, up_pin, dn_pin;
	psg_pkg::psg_gain_set_t gains;
	int errors = 0, n_checks = 0;

	always #5 pclk = ~pclk;

	psg_sensor_model psg_sensor_model_i (.pclk(pclk), .presetn(presetn), .fb_req(fb_req),
		.sp_req(sp_req), .rst_req(rreq), .up_req(up), .dn_req(dn), .process_feedback(fb),
		.process_setpoint(sp), .reset_terminal_cmd(rst_pin), .keypad_up_key(up_pin),
		.keypad_down_key(dn_pin));

	psg_supervision_gain #(.FB_W(12)) psg_supervision_gain_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .process_feedback(fb),
		.process_setpoint(sp), .pid_raw(pid_raw), .dancer_feedback(dfb),
		.ext_dancer_ref(ext_ref), .keypad_reset_key(krst), .reset_terminal_cmd(rst_pin),
		.keypad_up_key(up_pin), .keypad_down_key(dn_pin), .input_terminals(terms),
		.supervision_flag_out(flag), .output_terminal(term), .pid_ref_out(pid_ref),
		.dancer_ref_out(dref), .gain_set2_out(gs2), .active_gains(gains));

	task automatic conclude();
		if (errors == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, x, s);
		end
	endtask : chk

	// The master holds every signal until the edge at which pready is sampled.
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic settle();
		repeat (6) @(posedge pclk);
	endtask : settle

	task automatic sup(input logic [11:0] f, input logic x);
		fb_req <= f;
		settle();
		chk("supervision_flag_out", {31'h0, flag}, {31'h0, x});
		chk("output_terminal", {31'h0, term}, {31'h0, x});
	endtask : sup

	task automatic clr(input logic by_key);
		if (by_key) krst <= 1'b1;
		else rreq <= 1'b1;
		settle();
		krst <= 1'b0;
		rreq <= 1'b0;
		settle();
	endtask : clr

	task automatic pid(input logic [15:0] raw, input logic [15:0] x);
		pid_raw <= raw;
		settle();
		chk("pid_ref_out", {16'h0000, pid_ref}, {16'h0000, x});
	endtask : pid

	task automatic dan(input logic [7:0] f, input logic x);
		dfb <= f;
		settle();
		chk("gain_set2_out", {31'h0, gs2}, {31'h0, x});
		chk("prop_gain", {16'h0000, gains.prop_gain}, x ? 32'h0000_1003 : 32'h0000_1000);
		chk("integ_time", {16'h0000, gains.integ_time}, x ? 32'h0000_1004 : 32'h0000_1001);
		chk("deriv_time", {16'h0000, gains.deriv_time}, x ? 32'h0000_1005 : 32'h0000_1002);
	endtask : dan

	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		conclude();
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `PSG_OFF_TRIP, 0);
		chk("trip_reset", r, 32'h0000_0064);
		apb(0, `PSG_OFF_CLAMP, 0);
		chk("clamp_reset", r, 32'h0000_0064);
		apb(0, 32'h0000_0038, 0);
		chk("unmapped_err", {31'h0, e}, 32'h1);
		chk("unmapped_data", r, 32'h0);
		apb(1, `PSG_OFF_TERM, 32'h0000_142A);
		// Abs normal band 409..2457, deviation band 1591..top with setpoint 2000.
		apb(1, `PSG_OFF_TRIP, 32'h000A_003C);
		sp_req <= 12'd2000;
		for (int c = 0; c < 8; c++) begin
			apb(1, `PSG_OFF_CFG, 32'(c));
			sup(12'd3000, !c[2]);
			sup(12'd1000, c[2] | c[1]);
			sup(12'd200, 1'b1);
			sup(12'd2000, c[1]);
			clr(c[0]);
			sup(12'd2000, 1'b0);
		end
		apb(0, `PSG_OFF_STATUS, 0);
		chk("hold_armed", {31'h0, r[1]}, 32'h1);
		apb(1, `PSG_OFF_CFG, 32'h0000_1000);
		fb_req <= 12'd2000;
		settle();
		chk("neg_term", {31'h0, term}, 32'h1);
		apb(1, `PSG_OFF_TERM, 32'h0000_142B);
		fb_req <= 12'd200;
		settle();
		chk("unassigned_flag", {31'h0, flag}, 32'h0);
		chk("unassigned_term", {31'h0, term}, 32'h0);
		apb(1, `PSG_OFF_TERM, 32'h0000_142A);
		// Hold chosen while tripping: the flag waits for one pass through the band.
		apb(1, `PSG_OFF_CFG, 32'h1);
		sup(12'd200, 1'b0);
		sup(12'd2000, 1'b0);
		sup(12'd200, 1'b1);
		apb(1, `PSG_OFF_CLAMP, 32'h000A_0032);
		pid(16'd800, 16'd500);
		pid(16'hFFCE, 16'd100);
		pid(16'd300, 16'd300);
		apb(1, `PSG_OFF_CLAMP, 32'h03E7_03E7);
		apb(1, `PSG_OFF_LIMIT, 32'h00C8_02BC);
		pid(16'd800, 16'd700);
		pid(16'd50, 16'd200);
		apb(1, `PSG_OFF_PRESET, 32'h0000_0384);
		terms <= 7'h01;
		pid(16'd800, 16'h0384);
		terms <= 7'h00;
		for (int i = 0; i < 6; i++) apb(1, `PSG_OFF_GAIN0 + 32'(4 * i), 32'h1000 + 32'(i));
		apb(1, `PSG_OFF_DANCER, 32'h0000_050A);
		dan(8'd12, 1'b1);
		dan(8'd15, 1'b1);
		dan(8'd16, 1'b0);
		dan(8'd5, 1'b1);
		dan(8'd4, 1'b0);
		chk("dancer_ref_out", {24'h0, dref}, 32'h0000_000A);
		apb(1, `PSG_OFF_DANCER, 32'h0000_000A);
		dan(8'd10, 1'b0);
		up <= 1'b1;
		settle();
		up <= 1'b0;
		settle();
		apb(0, `PSG_OFF_DANCER, 0);
		chk("key_up_store", {24'h0, r[7:0]}, 32'h0000_000B);
		dn <= 1'b1;
		settle();
		dn <= 1'b0;
		settle();
		chk("key_down_ref", {24'h0, dref}, 32'h0000_000A);
		apb(1, `PSG_OFF_DANCER, 32'h0000_0078);
		apb(0, `PSG_OFF_DANCER, 0);
		chk("ref_sat_hi", {24'h0, r[7:0]}, 32'h0000_0064);
		apb(1, `PSG_OFF_DANCER, 32'h0000_009C);
		apb(0, `PSG_OFF_DANCER, 0);
		chk("ref_min", {24'h0, r[7:0]}, 32'h0000_009C);
		apb(1, `PSG_OFF_DANCER, 32'h0000_0080);
		apb(0, `PSG_OFF_DANCER, 0);
		chk("ref_sat_lo", {24'h0, r[7:0]}, 32'h0000_009C);
		ext_ref <= 8'hE2;
		apb(1, `PSG_OFF_CFG, 32'h0000_0100);
		settle();
		chk("ext_ref_used", {24'h0, dref}, 32'h0000_00E2);
		conclude();
	end
endmodule : psg_supervision_gain_bench

`default_nettype wire
